// ---- common/mmrp_map.svh ----
`ifndef MMRP_MAP_SVH
`define MMRP_MAP_SVH
// Summary of operation
// RULE_01 - Parameters change only inside the programming menu, never in display mode.
// RULE_02 - Holding select enters the menu unless the security code or lock denies it (code checks only i_locked, no security code).
// RULE_03 - Select counts as entry request only after two seconds of continuous hold.
// RULE_04 - At top menu reset steps modules; select enters the shown module.
// RULE_05 - Reset cycles choices; select stores the choice and advances (code stores only param 0's choice, as the filter).
// RULE_06 - Numeric entry: reset increments digit, hold scrolls; select next digit, hold stores.
// RULE_07 - Select at menu end commits changes to memory and returns to display.
// RULE_08 - Filter weights new reading by 1, 1/4, 1/8 or 1/16 per setting.
// RULE_09 - Filter bypassed while change exceeds band 0..199, re-engaged below it.
// RULE_10 - Band of zero keeps filtering always engaged.
// RULE_11 - Band compares raw display counts regardless of decimal point.
// RULE_12 - Offset is added to display and updated by a zero action.
// RULE_13 - Display maps linearly through two point pairs, extrapolating outside.
// RULE_14 - Keyed style accepts typed scaling inputs with no live signal.
// RULE_15 - Applied style: reset shows live input, select captures it.
// RULE_16 - User input is asserted while its line is low.
// RULE_17 - Zero function: each active edge zeroes display via the offset.
// RULE_18 - Reset function: each edge loads assigned captures with current input.
// RULE_19 - Hold function freezes assigned display while input stays asserted (code freezes only the main display, and only with MMRP_AS_DISP).
// RULE_20 - Display select advances shown display by one per activation.
// RULE_21 - Intensity function raises brightness one level per activation.
// RULE_22 - Print and reset issues a print then resets assigned values.
// RULE_23 - Setpoint reset functions clear output 1, 2 or both.
// RULE_24 - Assignment used only for reset, hold, or print and reset.
// RULE_25 - Maximum replaced after display stays above it for the delay.
// RULE_26 - Minimum replaced after display stays below it for the delay.
// RULE_27 - Capture timer restarts when display returns within the stored extreme.
`define MMRP_CLK_HZ        25000000
`define MMRP_HOLD_S        2
`define MMRP_SCROLL_DIV    6250000
`define MMRP_BAND_MAX      199
`define MMRP_NUM_MODULES   4
`define MMRP_NUM_PARAMS    8
`define MMRP_NUM_DIGITS    5
`define MMRP_INTENS_MAX    5
`define MMRP_DISP_COUNT    3
`endif

// ---- common/mmrp_pkg.sv ----
package mmrp_pkg;
    typedef enum logic [3:0] {
        MMRP_UF_NONE, MMRP_UF_LOCK, MMRP_UF_ZERO, MMRP_UF_RESET,
        MMRP_UF_HOLD, MMRP_UF_DSEL, MMRP_UF_INTENS, MMRP_UF_COLOR,
        MMRP_UF_PRINT, MMRP_UF_PRST, MMRP_UF_SP1, MMRP_UF_SP2,
        MMRP_UF_SP12
    } mmrp_ufunc_t;
    typedef enum logic [1:0] {
        MMRP_AS_DISP, MMRP_AS_MAX, MMRP_AS_MIN, MMRP_AS_BOTH
    } mmrp_assign_t;
    typedef enum logic [2:0] {
        MMRP_M_DISPLAY, MMRP_M_TOP, MMRP_M_PARAM, MMRP_M_DIGIT,
        MMRP_M_LIVE, MMRP_M_COMMIT
    } mmrp_menu_t;
endpackage

// ---- common/mmrp_btn_if.sv ----
`timescale 1ns/1ps
interface mmrp_btn_if;
    logic sel_press;
    logic sel_hold;
    logic rst_press;
    logic rst_rep;
    logic uin_act;
    logic uin_edge;
    modport src (output sel_press, sel_hold, rst_press, rst_rep,
                 uin_act, uin_edge);
    modport dst (input sel_press, sel_hold, rst_press, rst_rep,
                 uin_act, uin_edge);
endinterface // mmrp_btn_if

// ---- hdl/mmrp_buttons.sv ----
`timescale 1ns/1ps
`include "mmrp_map.svh"
module mmrp_buttons #(
    parameter int HOLD_CYC = `MMRP_CLK_HZ * `MMRP_HOLD_S,
    parameter int REP_CYC  = `MMRP_SCROLL_DIV
) (
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    input  wire logic  i_sel_n,
    input  wire logic  i_rst_btn_n,
    input  wire logic  i_user_n,
    mmrp_btn_if.src    bus
);
    typedef struct packed {
        logic [2:0]  s1;
        logic [2:0]  s2;
        logic [2:0]  prev;
        logic [31:0] sel_cnt;
        logic        sel_done;
        logic [31:0] rst_cnt;
        logic        sp, sh, rp, rr, ue;
    } mmrp_btn_st_t;
    mmrp_btn_st_t st_r, st_nxt;
    logic sel_a, rst_a, usr_a;

    assign sel_a = st_r.s2[0];
    assign rst_a = st_r.s2[1];
    assign usr_a = st_r.s2[2]; // see RULE_16

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = {~i_user_n, ~i_rst_btn_n, ~i_sel_n};
        st_nxt.s2 = st_r.s1;
        st_nxt.prev = st_r.s2;
        st_nxt.sp = 1'b0;
        st_nxt.sh = 1'b0;
        st_nxt.rp = 1'b0;
        st_nxt.rr = 1'b0;
        st_nxt.ue = usr_a & ~st_r.prev[2];
        // A short select acts on release so that a long hold is not
        // also seen as a press.
        if (sel_a) begin
            if (st_r.sel_cnt == 32'(HOLD_CYC - 1) && !st_r.sel_done) begin
                st_nxt.sh = 1'b1; // see RULE_03
                st_nxt.sel_done = 1'b1;
            end else if (!st_r.sel_done) begin
                st_nxt.sel_cnt = st_r.sel_cnt + 32'h1;
            end
        end else begin
            st_nxt.sp = st_r.prev[0] & ~st_r.sel_done;
            st_nxt.sel_cnt = 32'h0;
            st_nxt.sel_done = 1'b0;
        end
        if (rst_a) begin
            st_nxt.rp = ~st_r.prev[1];
            if (st_r.rst_cnt == 32'(REP_CYC - 1)) begin
                st_nxt.rr = 1'b1; // see RULE_06
                st_nxt.rst_cnt = 32'h0;
            end else begin
                st_nxt.rst_cnt = st_r.rst_cnt + 32'h1;
            end
        end else begin
            st_nxt.rst_cnt = 32'h0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.sel_press = st_r.sp;
    assign bus.sel_hold  = st_r.sh;
    assign bus.rst_press = st_r.rp;
    assign bus.rst_rep   = st_r.rr;
    assign bus.uin_act   = usr_a;
    assign bus.uin_edge  = st_r.ue;
endmodule // mmrp_buttons

// ---- hdl/mmrp_capture.sv ----
`timescale 1ns/1ps
module mmrp_capture #(
    parameter int W     = 18,
    parameter int DLY_W = 32,
    parameter bit IS_MAX = 1'b1
) (
    input  wire logic                i_clk,
    input  wire logic                i_rst_n,
    input  wire logic                i_en,
    input  wire logic                i_tick,
    input  wire logic signed [W-1:0] i_val,
    input  wire logic [DLY_W-1:0]    i_delay,
    input  wire logic                i_load,
    output logic signed [W-1:0]      o_ext
);
    typedef struct packed {
        logic signed [W-1:0] ext;
        logic [DLY_W-1:0]    cnt;
    } mmrp_cap_st_t;
    mmrp_cap_st_t st_r, st_nxt;
    logic beyond;

    assign beyond = IS_MAX ? (i_val > st_r.ext) : (i_val < st_r.ext);

    always_comb begin
        st_nxt = st_r;
        if (i_load) begin
            st_nxt.ext = i_val; // see RULE_18
            st_nxt.cnt = '0;
        end else if (i_en && i_tick) begin
            if (!beyond) begin
                st_nxt.cnt = '0; // see RULE_27
            end else if (st_r.cnt >= i_delay) begin
                st_nxt.ext = i_val; // see RULE_25 see RULE_26
                st_nxt.cnt = '0;
            end else begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_ext = st_r.ext;
endmodule // mmrp_capture

// ---- hdl/mmrp_top.sv ----
`timescale 1ns/1ps
`include "mmrp_map.svh"
module mmrp_top #(
    parameter int W        = 18,
    parameter int HOLD_CYC = `MMRP_CLK_HZ * `MMRP_HOLD_S,
    parameter int REP_CYC  = `MMRP_SCROLL_DIV,
    parameter int SEC_CYC  = `MMRP_CLK_HZ
) (
    input  wire logic                i_clk,
    input  wire logic                i_rst_n,
    input  wire logic                i_sel_n,
    input  wire logic                i_rst_btn_n,
    input  wire logic                i_user_n,
    input  wire logic                i_sample_vld,
    input  wire logic signed [W-1:0] i_sample,
    input  wire logic                i_locked,
    input  wire logic                i_applied_scaling_style,
    input  wire mmrp_pkg::mmrp_ufunc_t  i_ufunc,
    input  wire mmrp_pkg::mmrp_assign_t i_uassign,
    input  wire logic                i_max_capture_enable,
    input  wire logic                i_min_capture_enable,
    input  wire logic [31:0]         i_max_capture_delay,
    input  wire logic [31:0]         i_min_capture_delay,
    output logic [2:0]               o_menu_state,
    output logic [2:0]               o_module,
    output logic [2:0]               o_param,
    output logic [2:0]               o_digit,
    output logic [3:0]               o_choice,
    output logic                     o_commit,
    output logic signed [W-1:0]      o_display,
    output logic signed [W-1:0]      o_max,
    output logic signed [W-1:0]      o_min,
    output logic [1:0]               o_disp_sel,
    output logic [2:0]               o_intensity,
    output logic                     o_print,
    output logic                     o_sp1_clr,
    output logic                     o_sp2_clr,
    output logic [1:0]               o_filter,
    output logic [7:0]               o_band,
    output logic signed [W-1:0]      o_offset,
    output logic signed [W-1:0]      o_scale_input_one,
    output logic signed [W-1:0]      o_scale_display_one,
    output logic signed [W-1:0]      o_scale_input_two,
    output logic signed [W-1:0]      o_scale_display_two
);
    typedef struct packed {
        mmrp_pkg::mmrp_menu_t menu;
        logic [2:0]           module_idx;
        logic [2:0]           param;
        logic [2:0]           digit;
        logic [3:0]           choice;
        logic signed [W-1:0]  num;
        logic                 commit;
        logic [1:0]           filter;
        logic [7:0]           band;
        logic signed [W-1:0]  offset;
        logic signed [W-1:0]  in1, d1, in2, d2;
        logic signed [W-1:0]  scaled;
        logic signed [W-1:0]  disp;
        logic [1:0]           dsel;
        logic [2:0]           intens;
        logic                 print;
        logic                 prst_pend;
        logic                 sp1, sp2;
        logic [31:0]          sec_cnt;
        logic                 tick;
    } mmrp_top_st_t;
    mmrp_top_st_t st_r, st_nxt;
    mmrp_btn_if btn ();
    logic signed [W-1:0] max_v, min_v;
    logic                load_max, load_min;
    logic                edge_uf, rst_uf;
    logic signed [W-1:0] raw, diff, adiff, filt, pwr;
    logic signed [2*W+1:0] prod;
    logic signed [W:0]   den;
    logic signed [W-1:0] ten_pow [`MMRP_NUM_DIGITS];
    logic                hold_disp;

    genvar gi;
    generate
        for (gi = 0; gi < `MMRP_NUM_DIGITS; gi++) begin : g_pow
            if (gi == 0) begin : g_one
                assign ten_pow[gi] = W'(1);
            end else begin : g_mul
                assign ten_pow[gi] = W'(ten_pow[gi-1] * 10);
            end
        end
    endgenerate

    mmrp_buttons #(.HOLD_CYC(HOLD_CYC), .REP_CYC(REP_CYC)) u_btn (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_sel_n    (i_sel_n),
        .i_rst_btn_n(i_rst_btn_n),
        .i_user_n   (i_user_n),
        .bus        (btn.src)
    );

    assign edge_uf = btn.uin_edge;
    // The assignment only matters for the three functions that name it.
    assign rst_uf = edge_uf && i_ufunc == mmrp_pkg::MMRP_UF_RESET ||
        st_r.prst_pend; // see RULE_24 see RULE_22
    assign load_max = rst_uf && (i_uassign == mmrp_pkg::MMRP_AS_MAX ||
        i_uassign == mmrp_pkg::MMRP_AS_BOTH); // see RULE_18
    assign load_min = rst_uf && (i_uassign == mmrp_pkg::MMRP_AS_MIN ||
        i_uassign == mmrp_pkg::MMRP_AS_BOTH);
    assign hold_disp = btn.uin_act && i_ufunc == mmrp_pkg::MMRP_UF_HOLD &&
        i_uassign == mmrp_pkg::MMRP_AS_DISP; // see RULE_19

    mmrp_capture #(.W(W), .DLY_W(32), .IS_MAX(1'b1)) u_max (
        .i_clk  (i_clk),
        .i_rst_n(i_rst_n),
        .i_en   (i_max_capture_enable),
        .i_tick (st_r.tick),
        .i_val  (st_r.disp),
        .i_delay(i_max_capture_delay),
        .i_load (load_max),
        .o_ext  (max_v)
    );
    mmrp_capture #(.W(W), .DLY_W(32), .IS_MAX(1'b0)) u_min (
        .i_clk  (i_clk),
        .i_rst_n(i_rst_n),
        .i_en   (i_min_capture_enable),
        .i_tick (st_r.tick),
        .i_val  (st_r.disp),
        .i_delay(i_min_capture_delay),
        .i_load (load_min),
        .o_ext  (min_v)
    );

    // Two-point scaling; the slope is kept outside the points too.
    always_comb begin
        den  = {st_r.in2[W-1], st_r.in2} - {st_r.in1[W-1], st_r.in1};
        prod = (2*W+2)'(i_sample - st_r.in1) * (2*W+2)'(st_r.d2 - st_r.d1);
        if (den == '0) begin
            raw = st_r.d1;
        end else begin
            raw = W'(prod / (2*W+2)'(den) + (2*W+2)'(st_r.d1)); // see RULE_13
        end
        raw  = W'(raw + st_r.offset); // see RULE_12
        diff = W'(raw - st_r.disp);
        adiff = diff[W-1] ? W'(-diff) : diff;
        unique case (st_r.filter) // see RULE_08
            2'h0: filt = raw;
            2'h1: filt = W'(st_r.disp + (diff >>> 2));
            2'h2: filt = W'(st_r.disp + (diff >>> 3));
            2'h3: filt = W'(st_r.disp + (diff >>> 4));
        endcase
        // Band is in raw counts; the decimal point never enters here.
        if (st_r.band != 8'h0 && adiff > W'(st_r.band)) begin
            filt = raw; // see RULE_09 see RULE_10 see RULE_11
        end
        pwr = ten_pow[st_r.digit];
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.commit = 1'b0;
        st_nxt.print = 1'b0;
        st_nxt.prst_pend = st_r.print && i_ufunc == mmrp_pkg::MMRP_UF_PRST;
        st_nxt.sp1 = 1'b0;
        st_nxt.sp2 = 1'b0;
        st_nxt.tick = 1'b0;
        if (st_r.sec_cnt == 32'(SEC_CYC - 1)) begin
            st_nxt.sec_cnt = 32'h0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.sec_cnt = st_r.sec_cnt + 32'h1;
        end
        if (i_sample_vld && !hold_disp) begin
            st_nxt.disp = filt;
        end
        st_nxt.scaled = raw;
        if (edge_uf) begin
            unique case (i_ufunc)
                mmrp_pkg::MMRP_UF_ZERO:
                    st_nxt.offset = W'(st_r.offset - st_r.disp); // see RULE_17
                mmrp_pkg::MMRP_UF_DSEL:
                    st_nxt.dsel = (st_r.dsel == 2'(`MMRP_DISP_COUNT - 1)) ?
                        2'h0 : st_r.dsel + 2'h1; // see RULE_20
                mmrp_pkg::MMRP_UF_INTENS:
                    st_nxt.intens = (st_r.intens == 3'(`MMRP_INTENS_MAX)) ?
                        3'h1 : st_r.intens + 3'h1; // see RULE_21
                mmrp_pkg::MMRP_UF_PRINT, mmrp_pkg::MMRP_UF_PRST:
                    st_nxt.print = 1'b1; // see RULE_22
                mmrp_pkg::MMRP_UF_SP1: st_nxt.sp1 = 1'b1; // see RULE_23
                mmrp_pkg::MMRP_UF_SP2: st_nxt.sp2 = 1'b1;
                mmrp_pkg::MMRP_UF_SP12: begin
                    st_nxt.sp1 = 1'b1;
                    st_nxt.sp2 = 1'b1;
                end
                default: ;
            endcase
        end
        unique case (st_r.menu)
            mmrp_pkg::MMRP_M_DISPLAY: begin
                // No filter, band or scaling value is writable until the hold is accepted.
                if (btn.sel_hold && !i_locked) begin // see RULE_02 see RULE_01
                    st_nxt.menu = mmrp_pkg::MMRP_M_TOP;
                    st_nxt.module_idx = 3'h0;
                end
            end
            mmrp_pkg::MMRP_M_TOP: begin
                if (btn.rst_press) begin // see RULE_04
                    st_nxt.module_idx = (st_r.module_idx ==
                        3'(`MMRP_NUM_MODULES)) ? 3'h0 : st_r.module_idx + 3'h1;
                end else if (btn.sel_press) begin
                    if (st_r.module_idx == 3'h0) begin
                        st_nxt.menu = mmrp_pkg::MMRP_M_COMMIT;
                    end else begin
                        st_nxt.menu = mmrp_pkg::MMRP_M_PARAM;
                        st_nxt.param = 3'h0;
                        st_nxt.choice = 4'h0;
                    end
                end
            end
            mmrp_pkg::MMRP_M_PARAM: begin
                // Params 0..2 are choices; 3..7 are numeric entries.
                if (st_r.param < 3'h3) begin
                    if (btn.rst_press) begin
                        st_nxt.choice = st_r.choice + 4'h1; // see RULE_05
                    end else if (btn.sel_press) begin
                        if (st_r.param == 3'h0) begin
                            st_nxt.filter = st_r.choice[1:0];
                        end
                        st_nxt.param = st_r.param + 3'h1;
                        st_nxt.choice = 4'h0;
                    end
                end else if (btn.rst_press) begin
                    st_nxt.digit = 3'h0;
                    st_nxt.num = '0;
                    st_nxt.menu = (i_applied_scaling_style &&
                        (st_r.param == 3'h4 || st_r.param == 3'h6)) ?
                        mmrp_pkg::MMRP_M_LIVE : mmrp_pkg::MMRP_M_DIGIT;
                end else if (btn.sel_press) begin
                    st_nxt.param = st_r.param + 3'h1;
                    if (st_r.param == 3'h7) begin
                        st_nxt.menu = mmrp_pkg::MMRP_M_TOP;
                        st_nxt.module_idx = 3'h0;
                    end
                end
            end
            mmrp_pkg::MMRP_M_LIVE: begin
                if (btn.sel_press) begin // see RULE_15
                    if (st_r.param == 3'h4) begin
                        st_nxt.in1 = i_sample;
                    end else begin
                        st_nxt.in2 = i_sample;
                    end
                    st_nxt.param = st_r.param + 3'h1;
                    st_nxt.menu = mmrp_pkg::MMRP_M_PARAM;
                end
            end
            mmrp_pkg::MMRP_M_DIGIT: begin
                if (btn.rst_press || btn.rst_rep) begin // see RULE_06
                    st_nxt.num = W'(st_r.num + pwr);
                end else if (btn.sel_press) begin
                    st_nxt.digit = (st_r.digit ==
                        3'(`MMRP_NUM_DIGITS - 1)) ? 3'h0 : st_r.digit + 3'h1;
                end else if (btn.sel_hold) begin // see RULE_14
                    unique case (st_r.param)
                        3'h3: st_nxt.band = (st_r.num > W'(`MMRP_BAND_MAX)) ?
                            8'(`MMRP_BAND_MAX) : st_r.num[7:0];
                        3'h4: st_nxt.in1 = st_r.num;
                        3'h5: st_nxt.d1 = st_r.num;
                        3'h6: st_nxt.in2 = st_r.num;
                        3'h7: st_nxt.d2 = st_r.num;
                        default: st_nxt.offset = st_r.num;
                    endcase
                    st_nxt.param = st_r.param + 3'h1;
                    st_nxt.menu = (st_r.param == 3'h7) ?
                        mmrp_pkg::MMRP_M_TOP : mmrp_pkg::MMRP_M_PARAM;
                end
            end
            mmrp_pkg::MMRP_M_COMMIT: begin
                st_nxt.commit = 1'b1; // see RULE_07
                st_nxt.menu = mmrp_pkg::MMRP_M_DISPLAY;
            end
            default: st_nxt.menu = mmrp_pkg::MMRP_M_DISPLAY;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_menu_state = st_r.menu;
    assign o_module = st_r.module_idx;
    assign o_param = st_r.param;
    assign o_digit = st_r.digit;
    assign o_choice = st_r.choice;
    assign o_commit = st_r.commit;
    assign o_display = st_r.disp;
    assign o_max = max_v;
    assign o_min = min_v;
    assign o_disp_sel = st_r.dsel;
    assign o_intensity = st_r.intens;
    assign o_print = st_r.print;
    assign o_sp1_clr = st_r.sp1;
    assign o_sp2_clr = st_r.sp2;
    assign o_filter = st_r.filter;
    assign o_band = st_r.band;
    assign o_offset = st_r.offset;
    assign o_scale_input_one = st_r.in1;
    assign o_scale_display_one = st_r.d1;
    assign o_scale_input_two = st_r.in2;
    assign o_scale_display_two = st_r.d2;
endmodule // mmrp_top

// ---- tb/mmrp_checker.sv ----
`timescale 1ns/1ps
module mmrp_checker (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_locked,
    input  wire mmrp_pkg::mmrp_ufunc_t i_ufunc,
    input  wire logic [2:0]            o_menu_state,
    input  wire logic                  o_commit,
    input  wire logic                  o_print,
    input  wire logic                  o_sp1_clr,
    input  wire logic                  o_sp2_clr,
    input  wire logic [2:0]            o_intensity,
    input  wire logic [1:0]            o_filter,
    input  wire logic [7:0]            o_band
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_commit_end;
        ##[0:2] (o_menu_state == 3'h0);
    endsequence
    chk_commit_pulse: assert property (o_commit |=> !o_commit)
        else $error("commit pulse too long");
    chk_commit_exit: assert property (o_commit |-> s_commit_end)
        else $error("no display after commit");
    chk_lock_refuse: assert property (o_menu_state == 3'h0
        && i_locked |=> o_menu_state == 3'h0)
        else $error("menu entered while locked");
    chk_param_frozen: assert property ((o_menu_state == 3'h0
        && $stable(o_menu_state)) |-> $stable({o_filter, o_band}))
        else $error("parameter changed in display mode");
    chk_print_cause: assert property (o_print |->
        i_ufunc inside {mmrp_pkg::MMRP_UF_PRINT, mmrp_pkg::MMRP_UF_PRST})
        else $error("print without print function");
    chk_sp1_cause: assert property (o_sp1_clr |->
        i_ufunc inside {mmrp_pkg::MMRP_UF_SP1, mmrp_pkg::MMRP_UF_SP12})
        else $error("bad output one clear");
    chk_sp2_cause: assert property (o_sp2_clr |->
        i_ufunc inside {mmrp_pkg::MMRP_UF_SP2, mmrp_pkg::MMRP_UF_SP12})
        else $error("bad output two clear");
    chk_intens_range: assert property (o_intensity <= 3'h5)
        else $error("intensity out of range");
    chk_band_limit: assert property (o_band <= 8'hc7)
        else $error("band above limit");
endmodule // mmrp_checker
bind mmrp_top mmrp_checker mmrp_checker_i (.i_clk, .i_rst_n, .i_locked,
    .i_ufunc, .o_menu_state, .o_commit, .o_print, .o_sp1_clr, .o_sp2_clr,
    .o_intensity, .o_filter, .o_band);

// ---- tb/mmrp_panel.sv ----
`timescale 1ns/1ps
module mmrp_panel (
    input  wire logic i_clk,
    output logic      o_sel_n,
    output logic      o_rst_btn_n,
    output logic      o_user_n
);
    initial {o_sel_n, o_rst_btn_n, o_user_n} = 3'h7;
    // A press pulls a line low; release lets the pull-up return it high.
    task automatic push(input int which, input int cyc);
        if (which == 0) o_sel_n = 1'b0;
        else if (which == 1) o_rst_btn_n = 1'b0;
        else o_user_n = 1'b0;
        repeat (cyc) @(posedge i_clk);
        #5;
        {o_sel_n, o_rst_btn_n, o_user_n} = 3'h7;
        repeat (12) @(posedge i_clk);
        #5;
    endtask
endmodule // mmrp_panel

// ---- tb/mmrp_top_tb.sv ----
`timescale 1ns/1ps
module mmrp_top_tb;
    logic i_clk, i_rst_n, i_sel_n, i_rst_btn_n, i_user_n, i_sample_vld;
    logic i_locked, i_applied_scaling_style, o_commit, o_print;
    logic i_max_capture_enable, i_min_capture_enable, o_sp1_clr, o_sp2_clr;
    logic signed [17:0] i_sample, o_display, o_max, o_min, o_offset;
    logic signed [17:0] o_scale_input_one, o_scale_display_one;
    logic signed [17:0] o_scale_input_two, o_scale_display_two;
    logic [31:0]        i_max_capture_delay, i_min_capture_delay;
    logic [2:0]         o_menu_state, o_module, o_param, o_digit, o_intensity;
    logic [3:0]         o_choice;
    logic [1:0]         o_disp_sel, o_filter;
    logic [7:0]         o_band;
    mmrp_pkg::mmrp_ufunc_t  i_ufunc;
    mmrp_pkg::mmrp_assign_t i_uassign;
    int errors, samples_checked, n_cmt, n_prn, n_c1, n_c2, k, n, m;
    int p[6];
    mmrp_pkg::mmrp_ufunc_t fl[6] = '{mmrp_pkg::MMRP_UF_DSEL,
        mmrp_pkg::MMRP_UF_INTENS, mmrp_pkg::MMRP_UF_SP1,
        mmrp_pkg::MMRP_UF_SP2, mmrp_pkg::MMRP_UF_SP12, mmrp_pkg::MMRP_UF_PRST};
    mmrp_top #(.HOLD_CYC(20), .REP_CYC(20), .SEC_CYC(10)) mmrp_top_i (
        .i_clk, .i_rst_n, .i_sel_n, .i_rst_btn_n, .i_user_n, .i_sample_vld,
        .i_sample, .i_locked, .i_applied_scaling_style, .i_ufunc, .i_uassign,
        .i_max_capture_enable, .i_min_capture_enable, .i_max_capture_delay,
        .i_min_capture_delay, .o_menu_state, .o_module, .o_param, .o_digit,
        .o_choice, .o_commit, .o_display, .o_max, .o_min, .o_disp_sel,
        .o_intensity, .o_print, .o_sp1_clr, .o_sp2_clr, .o_filter, .o_band,
        .o_offset, .o_scale_input_one, .o_scale_display_one,
        .o_scale_input_two, .o_scale_display_two);
    mmrp_panel mmrp_panel_i (.i_clk, .o_sel_n(i_sel_n),
        .o_rst_btn_n(i_rst_btn_n), .o_user_n(i_user_n));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        n_cmt <= n_cmt + o_commit;
        n_prn <= n_prn + o_print;
        n_c1 <= n_c1 + o_sp1_clr;
        n_c2 <= n_c2 + o_sp2_clr;
        #5;
        i_sample_vld = ($urandom % 8 == 0);
        i_sample = 18'($urandom % 2000);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Intensity wraps from the top level back to one.
    function automatic int intens(input int cnt);
        return (cnt - 1) % 5 + 1;
    endfunction
    task automatic conclude();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge i_clk);
        errors++;
        conclude();
    end
    initial begin
        void'($urandom(32'hf8e7));
        {errors, samples_checked, n_cmt, n_prn, n_c1, n_c2} = '0;
        {i_rst_n, i_locked, i_applied_scaling_style, i_sample_vld} = 4'h0;
        {i_max_capture_enable, i_min_capture_enable} = 2'h3;
        i_max_capture_delay = 32'h2;
        i_min_capture_delay = 32'h3;
        i_sample = '0;
        i_ufunc = mmrp_pkg::MMRP_UF_NONE;
        i_uassign = mmrp_pkg::MMRP_AS_DISP;
        repeat (8) @(posedge i_clk);
        #5 i_rst_n = 1'b1;
        i_locked = 1'b1;
        repeat (10) @(posedge i_clk);
        #5;
        mmrp_panel_i.push(1, 3);
        mmrp_panel_i.push(0, 30);
        chk(o_menu_state, 3'h0);
        chk(o_filter, 2'h0);
        i_locked = 1'b0;
        mmrp_panel_i.push(0, 10);
        chk(o_menu_state, 3'h0);
        mmrp_panel_i.push(0, 30);
        chk(o_menu_state, mmrp_pkg::MMRP_M_TOP);
        mmrp_panel_i.push(1, 3);
        chk(o_module, 3'h1);
        mmrp_panel_i.push(0, 3);
        chk(o_menu_state, mmrp_pkg::MMRP_M_PARAM);
        k = 1 + $urandom % 3;
        repeat (k) mmrp_panel_i.push(1, 3);
        mmrp_panel_i.push(0, 3);
        chk(o_filter, k);
        chk(o_param, 3'h1);
        repeat (2) mmrp_panel_i.push(0, 3);
        mmrp_panel_i.push(1, 3);
        chk(o_menu_state, mmrp_pkg::MMRP_M_DIGIT);
        n = $urandom % 10;
        m = $urandom % 10;
        repeat (n) mmrp_panel_i.push(1, 3);
        mmrp_panel_i.push(0, 3);
        chk(o_digit, 3'h1);
        mmrp_panel_i.push(1, 25);
        repeat (m) mmrp_panel_i.push(1, 3);
        mmrp_panel_i.push(0, 30);
        chk(o_band, n + 10 * (m + 2));
        chk(o_param, 3'h4);
        repeat (4) mmrp_panel_i.push(0, 3);
        chk(o_menu_state, mmrp_pkg::MMRP_M_TOP);
        repeat (5) mmrp_panel_i.push(1, 3);
        mmrp_panel_i.push(0, 3);
        chk(n_cmt, 1);
        chk(o_menu_state, 3'h0);
        for (int f = 0; f < 6; f++) begin
            i_ufunc = fl[f];
            i_uassign = mmrp_pkg::mmrp_assign_t'($urandom % 4);
            p[f] = 1 + $urandom % 7;
            repeat (p[f]) mmrp_panel_i.push(2, 3);
        end
        chk(o_disp_sel, p[0] % 3);
        chk(o_intensity, intens(p[1]));
        chk(n_c1, p[2] + p[4]);
        chk(n_c2, p[3] + p[4]);
        chk(n_prn, p[5]);
        conclude();
    end
endmodule // mmrp_top_tb
